/* File: hdl/eac_ctrl.sv */
`timescale 1ns/1ps
`include "eac_consts.svh"
module eac_ctrl
  import eac_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `EAC_PROG_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire eac_io_req_t io_req,
  input  wire logic        global_irq_enable,
  output logic [7:0]       io_rdata,
  output logic             cpu_stall,
  output logic             ready_irq
);
  logic [7:0]  mem [0:511];
  logic [8:0]  addr_reg, addr_next;
  logic [7:0]  data_reg, data_next;
  logic        rie_reg, rie_next, arm_reg, arm_next;
  logic        wstb_reg, wstb_next, rstb_reg, rstb_next;
  logic [2:0]  arm_cnt_reg, arm_cnt_next, stall_reg, stall_next;
  logic [22:0] prog_cnt_reg, prog_cnt_next;
  eac_state_t  state_reg, state_next;
  logic [7:0]  rdata_next;
  logic        irq_next;
  logic        cpu_stall_next;
  // Length of the current strobe-high stretch, read only by the checks
  logic [22:0] wstb_len_reg, wstb_len_next;
  logic        wr_ctl, wr_adl, wr_adh, wr_dat, start_wr, start_rd, abort;
  logic [7:0]  ctl_view;

  function automatic logic hit(input eac_io_req_t r, input logic [5:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  assign ctl_view = {4'h0, rie_reg, arm_reg, wstb_reg, rstb_reg};
  assign wr_ctl = hit(io_req, `EAC_OFS_CONTROL);
  assign wr_adl = hit(io_req, `EAC_OFS_ADDR_LOW);
  assign wr_adh = hit(io_req, `EAC_OFS_ADDR_HIGH);
  assign wr_dat = hit(io_req, `EAC_OFS_DATA);
  // Strobes ignored while busy; no new write until the old one ends
  assign start_wr = wr_ctl && io_req.wdata[`EAC_BIT_WSTB] && arm_reg && !wstb_reg;
  assign start_rd = wr_ctl && io_req.wdata[`EAC_BIT_RSTB] && !wstb_reg && !start_wr;
  assign abort = (state_reg == EAC_PROG) && (wr_adl || wr_adh || wr_dat);

  always_comb begin
    addr_next     = addr_reg;
    data_next     = data_reg;
    rie_next      = rie_reg;
    arm_next      = arm_reg;
    wstb_next     = wstb_reg;
    rstb_next     = 1'b0;
    arm_cnt_next  = arm_cnt_reg;
    stall_next    = (stall_reg != 3'h0) ? stall_reg - 3'h1 : 3'h0;
    prog_cnt_next = prog_cnt_reg;
    state_next    = state_reg;
    wstb_len_next = wstb_reg ? wstb_len_reg + 23'h1 : 23'h0;
    if (wr_adl) begin
      addr_next[7:0] = io_req.wdata;
    end
    if (wr_adh) begin
      addr_next[8] = io_req.wdata[0];
    end
    if (wr_dat) begin
      data_next = io_req.wdata;
    end
    if (arm_reg) begin
      if (arm_cnt_reg == `EAC_ARM_CYCLES - 3'h1) begin
        arm_next = 1'b0;
      end
      arm_cnt_next = arm_cnt_reg + 3'h1;
    end
    if (wr_ctl) begin
      rie_next = io_req.wdata[`EAC_BIT_RDY_IE];
      if (io_req.wdata[`EAC_BIT_ARM] && !io_req.wdata[`EAC_BIT_WSTB]) begin
        arm_next     = 1'b1;
        arm_cnt_next = 3'h0;
      end
    end
    if (start_wr) begin
      wstb_next     = 1'b1;
      arm_next      = 1'b0;
      state_next    = EAC_PROG;
      prog_cnt_next = 23'(PROG_CYCLES - 1);
      stall_next    = `EAC_WR_STALL;
    end else if (start_rd) begin
      data_next  = mem[addr_reg];
      rstb_next  = 1'b1;
      stall_next = `EAC_RD_STALL;
    end
    if (state_reg == EAC_PROG) begin
      if (abort || prog_cnt_reg == 23'h0) begin
        wstb_next  = 1'b0;
        state_next = EAC_IDLE;
      end else begin
        prog_cnt_next = prog_cnt_reg - 23'h1;
      end
    end
    case (io_req.addr)
      `EAC_OFS_ADDR_LOW:  rdata_next = addr_reg[7:0];
      `EAC_OFS_ADDR_HIGH: rdata_next = {7'h00, addr_reg[8]};
      `EAC_OFS_DATA:      rdata_next = data_reg;
      `EAC_OFS_CONTROL:   rdata_next = ctl_view;
      default:            rdata_next = 8'h00;
    endcase
    irq_next = global_irq_enable && rie_next && !wstb_next;
    cpu_stall_next = (stall_next != 3'h0);
  end

  // Array kept out of reset; contents survive reset like the real cells
  always_ff @(posedge clk) begin
    if (state_reg == EAC_PROG && prog_cnt_reg == 23'h0 && !abort) begin
      mem[addr_reg] <= data_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg     <= `EAC_RST_ADDR;
      data_reg     <= `EAC_RST_DATA;
      rie_reg      <= `EAC_RST_BIT;
      arm_reg      <= `EAC_RST_BIT;
      wstb_reg     <= `EAC_RST_BIT;
      rstb_reg     <= `EAC_RST_BIT;
      arm_cnt_reg  <= 3'h0;
      stall_reg    <= 3'h0;
      prog_cnt_reg <= 23'h0;
      state_reg    <= EAC_IDLE;
      io_rdata     <= 8'h00;
      cpu_stall    <= 1'b0;
      ready_irq    <= 1'b0;
      wstb_len_reg <= 23'h0;
    end else begin
      addr_reg     <= addr_next;
      data_reg     <= data_next;
      rie_reg      <= rie_next;
      arm_reg      <= arm_next;
      wstb_reg     <= wstb_next;
      rstb_reg     <= rstb_next;
      arm_cnt_reg  <= arm_cnt_next;
      stall_reg    <= stall_next;
      prog_cnt_reg <= prog_cnt_next;
      state_reg    <= state_next;
      io_rdata     <= rdata_next;
      cpu_stall    <= cpu_stall_next;
      ready_irq    <= irq_next;
      wstb_len_reg <= wstb_len_next;
    end
  end

  property p_arm_timeout;
    @(posedge clk) disable iff (rst)
      $rose(arm_reg) |-> ##[1:4] !arm_reg;
  endproperty
  a_arm_timeout: assert property (p_arm_timeout) else $error("arm did not time out");
  property p_no_unarmed_write;
    @(posedge clk) disable iff (rst)
      (wr_ctl && io_req.wdata[`EAC_BIT_WSTB] && !arm_reg && !wstb_reg) |=> !wstb_reg;
  endproperty
  a_no_unarmed_write: assert property (p_no_unarmed_write) else $error("unarmed write");
  property p_wr_stall;
    @(posedge clk) disable iff (rst)
      start_wr |=> cpu_stall ##1 cpu_stall ##1 !cpu_stall;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write stall not two");
  property p_rd_stall;
    @(posedge clk) disable iff (rst)
      start_rd |=> cpu_stall [*4] ##1 !cpu_stall;
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read stall not four");
  property p_rd_clear;
    @(posedge clk) disable iff (rst)
      rstb_reg |=> !rstb_reg;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read strobe stuck");
  property p_rd_data;
    @(posedge clk) disable iff (rst)
      start_rd |=> data_reg == mem[$past(addr_reg)];
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
  property p_irq;
    @(posedge clk) disable iff (rst)
      ready_irq == ($past(global_irq_enable) && rie_reg && !wstb_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("ready irq wrong");
  property p_ctl_reserved;
    @(posedge clk) disable iff (rst)
      (io_req.addr == `EAC_OFS_CONTROL) |=> io_rdata[7:4] == 4'h0;
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved nonzero");
  property p_abort;
    @(posedge clk) disable iff (rst)
      abort |=> !wstb_reg && state_reg == EAC_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  // Aborted writes excluded; they end early and leave the byte unwritten
  property p_prog_len;
    @(posedge clk) disable iff (rst)
      $fell(wstb_reg) && !$past(abort) |-> wstb_len_reg == 23'(PROG_CYCLES);
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming time wrong");
  property p_mem_store;
    @(posedge clk) disable iff (rst)
      $fell(wstb_reg) && !$past(abort) |-> mem[$past(addr_reg)] == $past(data_reg);
  endproperty
  a_mem_store: assert property (p_mem_store) else $error("byte not stored");
  property p_addr_high_read;
    @(posedge clk) disable iff (rst)
      (io_req.addr == `EAC_OFS_ADDR_HIGH) |=> io_rdata[7:1] == 7'h00;
  endproperty
  a_addr_high_read: assert property (p_addr_high_read) else $error("high bits nonzero");
  property p_stall_cause;
    @(posedge clk) disable iff (rst)
      $rose(cpu_stall) |-> $past(start_wr || start_rd);
  endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without strobe");
  // Main scenarios
  c_write: cover property (@(posedge clk) disable iff (rst) start_wr ##[1:8] !arm_reg);
  c_done: cover property (@(posedge clk) disable iff (rst) $fell(wstb_reg) && !abort);
  c_read: cover property (@(posedge clk) disable iff (rst) start_rd);
  c_abort: cover property (@(posedge clk) disable iff (rst) abort);
endmodule // eac_ctrl

/* File: hdl/eac_consts.svh */
`ifndef EAC_CONSTS_SVH
`define EAC_CONSTS_SVH
// How it works
// - Nine-bit address indexes bytes 0..511 linearly
// - Data register feeds writes, receives reads
// - Control bits 7..4 always read zero
// - Ready interrupt held while write strobe zero
// - Write arm self-clears four cycles after set
// - Write strobe programs only when armed
// - Strobe clears when programming time elapses
// - Write strobe stalls processor two cycles
// - Read strobe fetches byte, then self-clears
// - Read strobe stalls processor four cycles
// - Address/data write during programming aborts it
`define EAC_OFS_ADDR_LOW   6'h1E
`define EAC_OFS_ADDR_HIGH  6'h1F
`define EAC_OFS_DATA       6'h1D
`define EAC_OFS_CONTROL    6'h1C
`define EAC_BIT_RDY_IE     3
`define EAC_BIT_ARM        2
`define EAC_BIT_WSTB       1
`define EAC_BIT_RSTB       0
`define EAC_ARM_CYCLES     3'h4
`define EAC_WR_STALL       3'h2
`define EAC_RD_STALL       3'h4
`define EAC_RST_ADDR       9'h000
`define EAC_RST_DATA       8'h00
`define EAC_RST_BIT        1'b0
`define EAC_CLK_PERIOD_NS  5
`define EAC_PROG_TIME_US   2500
`define EAC_PROG_CYCLES    ((`EAC_PROG_TIME_US * 1000) / `EAC_CLK_PERIOD_NS)
`endif

/* File: hdl/eac_pkg.sv */
package eac_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } eac_io_req_t;
  typedef enum logic [1:0] {EAC_IDLE, EAC_PROG} eac_state_t;
endpackage

/* File: dv/eac_tb.sv */
`timescale 1ns/1ps
`define TB_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
  import eac_pkg::*;
  localparam int unsigned PROG = 20;
  logic        clk;
  logic        rst;
  eac_io_req_t io_req;
  logic        gie;
  logic [7:0]  io_rdata;
  logic        cpu_stall;
  logic        ready_irq;
  int          errors;
  int          compares;
  int          n;
  logic [7:0]  v;

  // Short programming time keeps the run small
  eac_ctrl #(.PROG_CYCLES(PROG)) eac_ctrl_i (.clk(clk), .rst(rst), .io_req(io_req),
    .global_irq_enable(gie), .io_rdata(io_rdata), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req.wr <= 1'b1;
    io_req.addr <= a;
    io_req.wdata <= d;
    @(posedge clk);
    io_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    io_req.addr <= a;
    @(posedge clk);
    #1 d = io_rdata;
  endtask

  task automatic stall_len(output int k);
    k = 0;
    #1;
    while (cpu_stall === 1'b1 && k < 10) begin
      k++;
      @(posedge clk);
      #1;
    end
  endtask

  task automatic set_addr(input logic [8:0] a);
    wr(6'h1E, a[7:0]);
    wr(6'h1F, {7'h00, a[8]});
  endtask

  task automatic prog(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    gie <= 1'b0;
    @(posedge clk);
    #1 `TB_CHK("irq_masked", 1'b0, ready_irq)
    set_addr(a);
    wr(6'h1D, d);
    wr(6'h1C, 8'h0C);
    wr(6'h1C, 8'h0A);
    gie <= 1'b1;
    stall_len(n);
    `TB_CHK("wr_stall", 2, n)
    rd(6'h1C, v);
    `TB_CHK("ctl_busy", 8'h0A, v)
    `TB_CHK("irq_busy", 1'b0, ready_irq)
    n = 0;
    while (v[1] !== 1'b0 && n < 40) begin
      rd(6'h1C, v);
      n++;
    end
    `TB_CHK("prog_long", 1'b1, n > 4)
    `TB_CHK("ctl_done", 8'h08, v)
    @(posedge clk);
    #1 `TB_CHK("irq_ready", 1'b1, ready_irq)
  endtask

  task automatic fetch(input logic [8:0] a, output logic [7:0] d);
    set_addr(a);
    rd(6'h1C, d);
    `TB_CHK("rd_idle", 1'b0, d[1])
    wr(6'h1C, 8'h01);
    stall_len(n);
    `TB_CHK("rd_stall", 4, n)
    rd(6'h1C, d);
    `TB_CHK("rd_clear", 8'h00, d)
    rd(6'h1D, d);
  endtask

  task automatic t_reset;
    rd(6'h1C, v);
    `TB_CHK("ctl_reset", 8'h00, v)
    `TB_CHK("stall_reset", 1'b0, cpu_stall)
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(6'h1F, 8'hFF);
    rd(6'h1F, v);
    `TB_CHK("addr_high", 8'h01, v)
    wr(6'h1C, 8'hF0);
    rd(6'h1C, v);
    `TB_CHK("ctl_reserved", 8'h00, v)
    wr(6'h10, 8'hFF);
    rd(6'h10, v);
    `TB_CHK("unmapped", 8'h00, v)
    wr(6'h1D, 8'h5A);
    rd(6'h1D, v);
    `TB_CHK("data_reg", 8'h5A, v)
    $display("test registers done");
  endtask

  task automatic t_write;
    prog(9'h1FF, 8'hA5);
    prog(9'h0FF, 8'h3C);
    fetch(9'h1FF, v);
    `TB_CHK("mem_top", 8'hA5, v)
    fetch(9'h0FF, v);
    `TB_CHK("mem_low", 8'h3C, v)
    $display("test write read done");
  endtask

  task automatic t_refuse;
    wr(6'h1D, 8'h77);
    wr(6'h1C, 8'h02);
    stall_len(n);
    `TB_CHK("unarmed_stall", 0, n)
    wr(6'h1C, 8'h04);
    repeat (6) @(posedge clk);
    rd(6'h1C, v);
    `TB_CHK("arm_timeout", 8'h00, v)
    wr(6'h1C, 8'h02);
    rd(6'h1C, v);
    `TB_CHK("late_strobe", 8'h00, v)
    fetch(9'h0FF, v);
    `TB_CHK("mem_kept", 8'h3C, v)
    $display("test refusal done");
  endtask

  task automatic t_abort;
    wr(6'h1C, 8'h04);
    wr(6'h1C, 8'h02);
    wr(6'h1D, 8'h11);
    rd(6'h1C, v);
    `TB_CHK("abort_ctl", 8'h00, v)
    $display("test abort done");
  endtask

  initial begin
    io_req = '0;
    gie = 1'b0;
    rst = 1'b1;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_write;
    t_refuse;
    t_abort;
    final_report;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(5 * 4000);
    errors++;
    final_report;
  end
endmodule // testbench
